// ---- dv/ret_stack_model.sv ----
// Return stack model that feeds stack_top to the return block.
// Assumes pushes come from the bench and pops are the block's pulses.
`timescale 1ns/10ps
`default_nettype none
module ret_stack_model (
   input  wire logic        mclk,
   input  wire logic        clk_en,
   input  wire logic        push,
   input  wire logic [12:0] push_val,
   input  wire logic        stack_pop,
   output logic [12:0]      stack_top
);
   logic [12:0] q[$];
   // Stack shares the core enable, so a frozen cycle pops nothing
   always @(posedge mclk)
   if (clk_en)
   begin
      if (stack_pop && q.size() > 0)
         void'(q.pop_back());
      if (push)
         q.push_back(push_val);
      // Empty stack shows a junk pattern, never a stale address
      stack_top <= (q.size() > 0) ? q[$] : 13'h1_5A5;
   end
endmodule // ret_stack_model
`default_nettype wire

// ---- dv/tb_return_instruction_exec.sv ----
// Bench for the return block: three return kinds against a stack model.
// Assumes clk_en held high except one frozen cycle, and one return per three cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_return_instruction_exec;
   import ret_exec_pkg::*;
   logic        mclk = 0, reset = 1, clk_en = 1, instr_valid = 0, intctl_we = 0, push = 0;
   logic [13:0] instr = 0;
   logic [12:0] stack_top, pc_value, push_val = 0;
   logic [7:0]  intctl_wdata = 0, w_reg, interrupt_control_reg, exp_w = 0;
   logic        stack_pop, pc_load, flush, busy, w_load, status_we;
   int          n_mismatch = 0, n_compared = 0, seed = 94, cyc = 0, k, r;
   return_instruction_exec i_return_instruction_exec (.mclk, .reset, .clk_en, .instr_valid,
      .instr, .stack_top, .intctl_we, .intctl_wdata, .stack_pop, .pc_load, .pc_value,
      .flush, .busy, .w_reg, .w_load, .interrupt_control_reg, .status_we);
   ret_stack_model i_ret_stack_model (.mclk, .clk_en, .push, .push_val, .stack_pop,
      .stack_top);
   initial
      forever #25 mclk = ~mclk;
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Hang guard: the sequence needs about 50 cycles
   always @(posedge mclk)
      if (++cyc > 400)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   initial
   begin
      repeat (5) @(negedge mclk);
      reset = 0;
      for (k = 0; k < 15; k++)
      begin
         push = 1;
         push_val = 13'($random(seed));
         intctl_we = 1;
         intctl_wdata = 8'($random(seed)) & 8'h7F;
         @(negedge mclk);
         push = 0;
         intctl_we = 0;
         r = $random(seed);
         instr_valid = 1;
         instr = (k % 3 == 0) ? OP_RETURN : (k % 3 == 1) ? OP_RET_INT : {OP_RET_LIT_HI, 10'(r)};
         if (k % 3 == 2)
            exp_w = 8'(r);
         @(negedge mclk);
         // Second cycle: a return offered now must be dropped
         instr = OP_RETURN;
         chk({stack_pop, pc_load, flush, busy, status_we}, 5'b1_1110);
         chk(pc_value, push_val);
         chk({w_load, w_reg}, {k % 3 == 2, exp_w});
         chk(interrupt_control_reg[7], k % 3 == 1);
         if (k == 4)
         begin
            // Frozen cycle: second-cycle pulses and pc must hold
            clk_en = 0;
            @(negedge mclk);
            chk({stack_pop, busy, pc_value}, {2'b11, push_val});
            clk_en = 1;
         end
         @(negedge mclk);
         instr_valid = 0;
         chk({stack_pop, pc_load, flush, busy, w_load}, 5'b0_0000);
      end
      tally_and_finish;
   end
endmodule // tb_return_instruction_exec
`default_nettype wire

// ---- rtl/ret_decode.sv ----
// Combinational decoder that classifies an instruction word as a return kind.
// Assumes the word is stable while instr_valid is high.
`timescale 1ns/10ps
`default_nettype none
module ret_decode
   import ret_exec_pkg::*;
(
   input  wire logic [ret_exec_pkg::INSN_W-1:0] instr,
   output ret_exec_pkg::ret_kind_e              kind
);
   always_comb
   begin
      // Bits 9:8 of the literal form are don't-care
      if (instr[13:10] == OP_RET_LIT_HI)
         kind = RK_LIT;
      else if (instr == OP_RETURN)
         kind = RK_RETURN;
      else if (instr == OP_RET_INT)
         kind = RK_INT;
      else
         kind = RK_NONE;
   end
endmodule // ret_decode
`default_nettype wire

// ---- rtl/ret_exec_pkg.sv ----
// Constants for the return-instruction decode and execute block.
// Assumes a 14-bit instruction word, 8-bit data path and 13-bit program counter.
package ret_exec_pkg;
   localparam int INSN_W = 14;
   localparam int DATA_W = 8;
   localparam int PC_W   = 13;
   localparam logic [13:0] OP_RETURN      = 14'h0008;
   localparam logic [13:0] OP_RET_INT     = 14'h0009;
   localparam logic [3:0]  OP_RET_LIT_HI  = 4'hD;
   localparam int          LIT_HI_POS     = 10;
   localparam int          GIE_POS        = 7;
   localparam logic [7:0]  WREG_RESET     = 8'h00;
   localparam logic [7:0]  INTCTL_RESET   = 8'h00;
   localparam logic [12:0] PC_RESET       = 13'h0000;
   typedef enum logic [1:0] {RK_NONE, RK_RETURN, RK_LIT, RK_INT} ret_kind_e;
endpackage

// ---- rtl/return_instruction_exec.sv ----
// Executes the three return instructions of the core.
// Assumes the fetch stage presents one word per enabled cycle and the
// stack supplies stack_top combinationally, popped on stack_pop.
`timescale 1ns/10ps
`default_nettype none
module return_instruction_exec
   import ret_exec_pkg::*;
(
   input  wire logic                             mclk,
   input  wire logic                             reset,
   input  wire logic                             clk_en,
   input  wire logic                             instr_valid,
   input  wire logic [ret_exec_pkg::INSN_W-1:0]  instr,
   input  wire logic [ret_exec_pkg::PC_W-1:0]    stack_top,
   input  wire logic                             intctl_we,
   input  wire logic [ret_exec_pkg::DATA_W-1:0]  intctl_wdata,
   output logic                                  stack_pop,
   output logic                                  pc_load,
   output logic [ret_exec_pkg::PC_W-1:0]         pc_value,
   output logic                                  flush,
   output logic                                  busy,
   output logic [ret_exec_pkg::DATA_W-1:0]       w_reg,
   output logic                                  w_load,
   output logic [ret_exec_pkg::DATA_W-1:0]       interrupt_control_reg,
   output logic                                  status_we
);
   import ret_exec_pkg::*;

   ret_kind_e  kind;
   logic       take;
   logic       take_lit;
   logic       take_int;
   logic       global_interrupt_enable;
   logic [1:0] ret_cycles_q;

   // Shared by the execute logic and the checks below
   function automatic logic is_literal(input ret_kind_e k);
      return k == RK_LIT;
   endfunction

   function automatic logic is_int_return(input ret_kind_e k);
      return k == RK_INT;
   endfunction

   ret_decode u_dec
   (
      .instr (instr),
      .kind  (kind)
   );

   // Second cycle of a return never accepts a new word
   assign take = clk_en && instr_valid && !busy && kind != RK_NONE;
   assign take_lit = take && is_literal(kind);
   assign take_int = take && is_int_return(kind);
   assign global_interrupt_enable = interrupt_control_reg[GIE_POS];

   // Cycle one: word taken; cycle two: pop, reload and flushed fetch slot together
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         stack_pop <= 1'b0;
         pc_load   <= 1'b0;
         pc_value  <= PC_RESET;
         busy      <= 1'b0;
         flush     <= 1'b0;
      end
      else if (clk_en)
      begin
         stack_pop <= take;
         pc_load   <= take;
         if (take)
            pc_value <= stack_top;
         busy  <= take;
         flush <= take;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         w_reg  <= WREG_RESET;
         w_load <= 1'b0;
      end
      else if (clk_en)
      begin
         w_load <= take_lit;
         if (take_lit)
            w_reg <= instr[DATA_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         interrupt_control_reg <= INTCTL_RESET;
      else if (clk_en)
      begin
         // Hardware set wins over a same-cycle software write
         if (intctl_we)
            interrupt_control_reg <= intctl_wdata;
         if (take_int)
            interrupt_control_reg[GIE_POS] <= 1'b1;
      end
   end

   // Returns never touch the status flags
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         status_we <= 1'b0;
      else if (clk_en)
         status_we <= 1'b0;
   end

   // Counts enabled busy cycles; a return must never stretch past two
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         ret_cycles_q <= 2'h0;
      else if (clk_en)
      begin
         if (busy)
            ret_cycles_q <= ret_cycles_q + 2'h1;
         else
            ret_cycles_q <= 2'h0;
      end
   end

   pop_loads_pc_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take |=> stack_pop && pc_load && pc_value == $past(stack_top))
      else $error("return did not reload pc from stack top");

   two_cycle_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take |=> busy && flush)
      else $error("return not two cycles");

   // A word offered in the second cycle must not start another pop
   no_back_to_back_a: assert property (@(posedge mclk) disable iff (reset)
      busy && clk_en |=> !stack_pop)
      else $error("word taken during return second cycle");

   literal_w_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take_lit |=> w_load && w_reg == $past(instr[7:0]))
      else $error("literal not loaded into w");

   literal_pop_a: assert property (@(posedge mclk) disable iff (reset)
      w_load |-> stack_pop && pc_load)
      else $error("literal return did not pop");

   gie_set_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take_int |=> global_interrupt_enable && stack_pop)
      else $error("interrupt return did not set enable");

   // Busy must drop on the next enabled edge, frozen edges excepted
   int_two_cycle_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take_int |=> busy && flush ##1 (!busy || !$past(clk_en)))
      else $error("interrupt return not two cycles");

   pop_pc_pair_a: assert property (@(posedge mclk) disable iff (reset)
      pc_load == stack_pop)
      else $error("pc load and pop out of step");

   flush_busy_pair_a: assert property (@(posedge mclk) disable iff (reset)
      flush == busy)
      else $error("flush and busy out of step");

   busy_len_a: assert property (@(posedge mclk) disable iff (reset)
      ret_cycles_q < 2'h2)
      else $error("return held busy too long");

   single_pulse_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && stack_pop |=> !stack_pop)
      else $error("pop pulse longer than one cycle");

   // Bits 9:8 must not influence the literal decode
   lit_decode_a: assert property (@(posedge mclk) disable iff (reset)
      instr[INSN_W-1:LIT_HI_POS] == OP_RET_LIT_HI |-> kind == RK_LIT)
      else $error("literal return not decoded");

   lit_only_w_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take && !take_lit |=> !w_load)
      else $error("w loaded by non-literal return");

   lit_pc_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take_lit |=> pc_load && pc_value == $past(stack_top))
      else $error("literal return pc not from stack");

   int_pc_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take_int |=> pc_load && pc_value == $past(stack_top))
      else $error("interrupt return pc not from stack");

   other_ignored_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && instr_valid && kind == RK_NONE |=> !stack_pop)
      else $error("non-return word popped stack");

   pc_hold_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && !take |=> pc_value == $past(pc_value))
      else $error("pc value moved without return");

   // Frozen cycles keep stack_pop and busy
   freeze_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !clk_en |=> stack_pop == $past(stack_pop) && busy == $past(busy))
      else $error("state moved while frozen");

   freeze_w_a: assert property (@(posedge mclk) disable iff (reset)
      !clk_en |=> w_reg == $past(w_reg) && pc_value == $past(pc_value))
      else $error("registers moved while frozen");

   set_wins_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && intctl_we && take_int |=> global_interrupt_enable)
      else $error("software write beat enable set");

   sw_write_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && intctl_we && !take_int |=> interrupt_control_reg == $past(intctl_wdata))
      else $error("software write lost");

   gie_kept_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take && !take_int && !intctl_we
      |=> global_interrupt_enable == $past(global_interrupt_enable))
      else $error("other return changed enable");

   status_quiet_a: assert property (@(posedge mclk) disable iff (reset)
      !status_we)
      else $error("return touched status flags");
   w_stable_a: assert property (@(posedge mclk) disable iff (reset)
      clk_en && take && kind != RK_LIT |=> w_reg == $past(w_reg))
      else $error("non-literal return changed w");
endmodule // return_instruction_exec
`default_nettype wire
